/* verilog/usf_pkg.sv */
// package: register offsets, field positions and reset values of the serial flag block
package usf_pkg;
  // register offsets (byte addresses on the plain port)
  localparam logic [3:0] ADDR_STATUS_ONE   = 4'h0;
  localparam logic [3:0] ADDR_STATUS_TWO   = 4'h1;
  localparam logic [3:0] ADDR_CONTROL_ONE  = 4'h2;
  localparam logic [3:0] ADDR_CONTROL_TWO  = 4'h3;
  localparam logic [3:0] ADDR_CONTROL_THREE = 4'h4;
  localparam logic [3:0] ADDR_DATA         = 4'h5;
  localparam logic [3:0] ADDR_IRQ_STATUS   = 4'h6;
  localparam logic [3:0] ADDR_IRQ_MASK     = 4'h7;
  // status one fields
  localparam int ST1_TX_EMPTY = 7;
  localparam int ST1_TX_DONE  = 6;
  localparam int ST1_RX_FULL  = 5;
  localparam int ST1_IDLE     = 4;
  localparam int ST1_OVERRUN  = 3;
  localparam int ST1_NOISE    = 2;
  localparam int ST1_FRAMING  = 1;
  localparam int ST1_PARITY   = 0;
  // status two fields
  localparam int ST2_RX_EDGE  = 7;
  // control one fields
  localparam int CT1_NINE_BIT = 4;
  // control two fields
  localparam int CT2_TX_EMPTY_MASK = 7;
  localparam int CT2_TX_DONE_MASK  = 6;
  localparam int CT2_RX_FULL_MASK  = 5;
  localparam int CT2_RX_ON         = 2;
  // control three fields
  localparam int CT3_RX_NINTH = 7;
  localparam int CT3_TX_NINTH = 6;
  // sticky event bits of the irq status register
  localparam int EV_RX_FULL  = 0;
  localparam int EV_ERROR    = 1;
  localparam int EV_RX_EDGE  = 2;
  localparam int EV_TX_EMPTY = 3;
  localparam int EV_TX_DONE  = 4;
  localparam int EV_IDLE     = 5;
  localparam int EV_COUNT    = 6;
  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_MASK    = 8'h00;
  // receive edge polarity: falling edge marks a start bit
  localparam logic       EDGE_ACTIVE_LEVEL = 1'b0;
endpackage

/* verilog/usf_edge_det.sv */
// receive pin edge detector gated by the receiver enable
`timescale 1ns/1ps
module usf_edge_det
  import usf_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  input  wire logic rx_on,
  input  wire logic rx_pin,
  output logic      edge_pulse
);
  logic pin_q;
  logic pin_d;

  // previous pin level, tracked only while enabled
  always_comb begin
    pin_d = rx_on ? rx_pin : 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_q <= 1'b1;
    end else if (clk_en) begin
      pin_q <= pin_d;
    end
  end

  // active edge: pin moves to the active level while receiver runs
  assign edge_pulse = clk_en && rx_on && (rx_pin == EDGE_ACTIVE_LEVEL)
                      && (pin_q != EDGE_ACTIVE_LEVEL);
endmodule

/* verilog/usf_core.sv */
// status flags, nine-bit data paths and register port of the serial interface
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module usf_core
  import usf_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // receive shifter side
  input  wire logic       rx_pin,
  input  wire logic       rx_char_ready,
  input  wire logic [8:0] rx_char_data,
  input  wire logic       rx_noise,
  input  wire logic       rx_framing,
  input  wire logic       rx_parity,
  input  wire logic       rx_line_idle,
  // transmit shifter side; mode, receiver enable and interrupt outputs
  input  wire logic       tx_shift_take,
  input  wire logic       tx_shift_done,
  output logic      [8:0] tx_shift_data,
  output logic            tx_shift_load,
  output logic            nine_bit_mode,
  output logic            rx_on,
  output logic            irq
);
  import usf_pkg::*;

  logic [7:0] ctl1_q, ctl1_d, ctl2_q, ctl2_d;
  logic       tx_ninth_q, tx_ninth_d, rx_ninth_q, rx_ninth_d;
  logic [7:0] rx_buf_q, rx_buf_d, tx_buf_q, tx_buf_d;
  logic       rx_full_q, rx_full_d, idle_q, idle_d, idle_armed_q, idle_armed_d;
  logic       ovr_q, ovr_d, nf_q, nf_d, fe_q, fe_d, pf_q, pf_d;
  logic       tx_empty_q, tx_empty_d, tx_done_q, tx_done_d, edge_q, edge_d;
  logic       st_seen_q, st_seen_d;
  logic [8:0] tx_sh_q, tx_sh_d;
  logic       tx_ld_q, tx_ld_d;
  logic [7:0] rdata_q, rdata_d;
  logic [EV_COUNT-1:0] ev_q, ev_d, mask_q, mask_d, ev_set;
  logic       edge_pulse, rd_st1, rd_data, wr_data, load_rx, overrun;
  logic [7:0] st1_val;

  usf_edge_det u_edge (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .clk_en     (clk_en),
    .rx_on      (rx_on),
    .rx_pin     (rx_pin),
    .edge_pulse (edge_pulse)
  );

  // decoded accesses
  assign rd_st1  = reg_rd && reg_addr == ADDR_STATUS_ONE;
  assign rd_data = reg_rd && reg_addr == ADDR_DATA;
  assign wr_data = reg_wr && reg_addr == ADDR_DATA;
  assign load_rx = rx_char_ready && !rx_full_q;
  assign overrun = rx_char_ready && rx_full_q;
  assign nine_bit_mode = ctl1_q[CT1_NINE_BIT];
  assign rx_on   = ctl2_q[CT2_RX_ON];
  assign tx_shift_data = tx_sh_q;
  assign tx_shift_load = tx_ld_q;
  assign reg_rdata = rdata_q;

  always_comb begin
    st1_val = 8'h00;
    st1_val[ST1_TX_EMPTY] = tx_empty_q;
    st1_val[ST1_TX_DONE]  = tx_done_q;
    st1_val[ST1_RX_FULL]  = rx_full_q;
    st1_val[ST1_IDLE]     = idle_q;
    st1_val[ST1_OVERRUN]  = ovr_q;
    st1_val[ST1_NOISE]    = nf_q;
    st1_val[ST1_FRAMING]  = fe_q;
    st1_val[ST1_PARITY]   = pf_q;
  end

  // next state of control, flags and data paths
  always_comb begin
    ctl1_d = ctl1_q;
    ctl2_d = ctl2_q;
    tx_ninth_d = tx_ninth_q;
    rx_ninth_d = rx_ninth_q;
    rx_buf_d = rx_buf_q;
    tx_buf_d = tx_buf_q;
    rx_full_d = rx_full_q;
    idle_d = idle_q;
    idle_armed_d = idle_armed_q;
    ovr_d = ovr_q;
    nf_d = nf_q;
    fe_d = fe_q;
    pf_d = pf_q;
    tx_empty_d = tx_empty_q;
    tx_done_d = tx_done_q;
    edge_d = edge_q;
    st_seen_d = st_seen_q;
    tx_sh_d = tx_sh_q;
    tx_ld_d = 1'b0;
    mask_d = mask_q;
    ev_set = '0;
    // control writes
    if (reg_wr && reg_addr == ADDR_CONTROL_ONE) begin
      ctl1_d = reg_wdata;
    end
    if (reg_wr && reg_addr == ADDR_CONTROL_TWO) begin
      ctl2_d = reg_wdata;
    end
    if (reg_wr && reg_addr == ADDR_CONTROL_THREE) begin
      tx_ninth_d = reg_wdata[CT3_TX_NINTH];
    end
    if (reg_wr && reg_addr == ADDR_IRQ_MASK) begin
      mask_d = reg_wdata[EV_COUNT-1:0];
    end
    // clear sequence: status read with flags set, then data read
    if (rd_st1) begin
      st_seen_d = rx_full_q || idle_q || ovr_q || nf_q || fe_q || pf_q;
    end
    if (rd_data && st_seen_q) begin
      st_seen_d = 1'b0;
      rx_full_d = 1'b0;
      idle_d = 1'b0;
      ovr_d = 1'b0;
      nf_d = 1'b0;
      fe_d = 1'b0;
      pf_d = 1'b0;
    end
    // received character: load buffer or flag an overrun (set wins)
    if (load_rx) begin
      rx_buf_d = rx_char_data[7:0];
      rx_ninth_d = nine_bit_mode ? rx_char_data[8] : 1'b0;
      rx_full_d = 1'b1;
      nf_d = rx_noise;
      fe_d = rx_framing;
      pf_d = rx_parity;
      idle_armed_d = 1'b1;
      ev_set[EV_RX_FULL] = 1'b1;
      ev_set[EV_ERROR] = rx_noise || rx_framing || rx_parity;
    end else if (overrun) begin
      ovr_d = 1'b1;
      ev_set[EV_ERROR] = 1'b1;
    end
    // idle flag sets once per received character
    if (rx_line_idle && idle_armed_q && !load_rx) begin
      idle_d = 1'b1;
      idle_armed_d = 1'b0;
      ev_set[EV_IDLE] = 1'b1;
    end
    // receive edge flag: write one clears, a new edge wins
    if (reg_wr && reg_addr == ADDR_STATUS_TWO && reg_wdata[ST2_RX_EDGE]) begin
      edge_d = 1'b0;
    end
    if (edge_pulse) begin
      edge_d = 1'b1;
      ev_set[EV_RX_EDGE] = 1'b1;
    end
    // transmit path
    if (tx_shift_done) begin
      tx_done_d = tx_empty_q;
      ev_set[EV_TX_DONE] = tx_empty_q;
    end
    if (wr_data) begin
      tx_buf_d = reg_wdata;
      tx_empty_d = 1'b0;
      tx_done_d = 1'b0;
    end else if (tx_shift_take && !tx_empty_q) begin
      tx_sh_d = {nine_bit_mode & tx_ninth_q, tx_buf_q};
      tx_ld_d = 1'b1;
      tx_empty_d = 1'b1;
      ev_set[EV_TX_EMPTY] = 1'b1;
    end
  end

  // sticky irq status: write one clears, set wins
  always_comb begin
    ev_d = ev_q;
    if (reg_wr && reg_addr == ADDR_IRQ_STATUS) begin
      ev_d = ev_q & ~reg_wdata[EV_COUNT-1:0];
    end
    ev_d = ev_d | ev_set;
  end

  // read data for the next cycle
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_STATUS_ONE:    rdata_d = st1_val;
        ADDR_STATUS_TWO:    rdata_d = {edge_q, 7'h00};
        ADDR_CONTROL_ONE:   rdata_d = ctl1_q;
        ADDR_CONTROL_TWO:   rdata_d = ctl2_q;
        ADDR_CONTROL_THREE: rdata_d = {rx_ninth_q, tx_ninth_q, 6'h00};
        ADDR_DATA:          rdata_d = rx_buf_q;
        ADDR_IRQ_STATUS:    rdata_d = {2'h0, ev_q};
        ADDR_IRQ_MASK:      rdata_d = {2'h0, mask_q};
        default:            rdata_d = 8'h00;
      endcase
    end
  end

  // level interrupt: unmasked sticky bits plus local flag masks
  assign irq = (|(ev_q & mask_q))
               || (tx_empty_q && ctl2_q[CT2_TX_EMPTY_MASK])
               || (tx_done_q && ctl2_q[CT2_TX_DONE_MASK])
               || (rx_full_q && ctl2_q[CT2_RX_FULL_MASK]);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctl1_q <= RST_CONTROL;
      ctl2_q <= RST_CONTROL;
      tx_ninth_q <= 1'b0;
      rx_ninth_q <= 1'b0;
      rx_buf_q <= 8'h00;
      tx_buf_q <= 8'h00;
      rx_full_q <= 1'b0;
      idle_q <= 1'b0;
      idle_armed_q <= 1'b0;
      ovr_q <= 1'b0;
      nf_q <= 1'b0;
      fe_q <= 1'b0;
      pf_q <= 1'b0;
      tx_empty_q <= 1'b1;
      tx_done_q <= 1'b1;
      edge_q <= 1'b0;
      st_seen_q <= 1'b0;
      tx_sh_q <= 9'h000;
      tx_ld_q <= 1'b0;
      rdata_q <= 8'h00;
      ev_q <= '0;
      mask_q <= RST_MASK[EV_COUNT-1:0];
    end else if (clk_en) begin
      ctl1_q <= ctl1_d;
      ctl2_q <= ctl2_d;
      tx_ninth_q <= tx_ninth_d;
      rx_ninth_q <= rx_ninth_d;
      rx_buf_q <= rx_buf_d;
      tx_buf_q <= tx_buf_d;
      rx_full_q <= rx_full_d;
      idle_q <= idle_d;
      idle_armed_q <= idle_armed_d;
      ovr_q <= ovr_d;
      nf_q <= nf_d;
      fe_q <= fe_d;
      pf_q <= pf_d;
      tx_empty_q <= tx_empty_d;
      tx_done_q <= tx_done_d;
      edge_q <= edge_d;
      st_seen_q <= st_seen_d;
      tx_sh_q <= tx_sh_d;
      tx_ld_q <= tx_ld_d;
      rdata_q <= rdata_d;
      ev_q <= ev_d;
      mask_q <= mask_d;
    end
  end

  // checks
  chk_full_sets_on_load: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && load_rx |=> rx_full_q) else $error("rx full not set on load");
  chk_full_clear_seq: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(rx_full_q) |-> $past(rd_data) && $past(st_seen_q))
    else $error("rx full cleared without sequence");
  chk_idle_clear_seq: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(idle_q) |-> $past(rd_data) && $past(st_seen_q))
    else $error("idle cleared without sequence");
  chk_idle_no_rearm: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(idle_q) |-> $past(idle_armed_q)) else $error("idle set without new char");
  chk_error_with_full: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && load_rx && rx_noise |=> nf_q && rx_full_q) else $error("noise not with full");
  chk_overrun_keeps: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && overrun && !rd_data |=> ovr_q && $stable(rx_buf_q))
    else $error("overrun handling wrong");
  chk_overrun_no_err: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && overrun && !nf_q && !(rd_data && st_seen_q) |=> !nf_q)
    else $error("noise set on overrun");
  chk_edge_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
    edge_pulse |=> edge_q) else $error("edge flag not set");
  chk_edge_needs_rx_on: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(edge_q) |-> $past(rx_on)) else $error("edge seen with receiver off");
  chk_ninth_copied: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(tx_ld_q) |-> tx_sh_q
      == {$past(nine_bit_mode) & $past(tx_ninth_q), $past(tx_buf_q)})
    else $error("ninth not copied");
  chk_tx_mask_irq: assert property (@(posedge core_clk) disable iff (sys_rst)
    tx_empty_q && !ctl2_q[CT2_TX_EMPTY_MASK] && !ctl2_q[CT2_TX_DONE_MASK]
    && !ctl2_q[CT2_RX_FULL_MASK] && mask_q == '0 |-> !irq) else $error("masked irq raised");
  cov_rx_clear: cover property (@(posedge core_clk) rd_st1 ##2 rd_data && rx_full_q);
  cov_overrun: cover property (@(posedge core_clk) clk_en && overrun);
  cov_edge: cover property (@(posedge core_clk) edge_pulse);
  cov_tx_load: cover property (@(posedge core_clk) tx_ld_q && tx_sh_q[8]);
endmodule

/* testbench/usf_peer_model.sv */
// far-side model: receive shifter events, line edges and transmit shifter
`timescale 1ns/1ps
module usf_peer_model (
  input  wire logic       core_clk,
  output logic            rx_pin,
  output logic            rx_char_ready,
  output logic      [8:0] rx_char_data,
  output logic      [2:0] rx_err,
  output logic            rx_line_idle,
  output logic            tx_shift_take,
  output logic            tx_shift_done,
  input  wire logic [8:0] tx_shift_data,
  input  wire logic       tx_shift_load
);
  // line idles high; released qualifiers carry junk, not the last value
  initial begin
    rx_pin = 1'b1;
    rx_char_ready = 1'b0;
    rx_char_data = 9'h155;
    rx_err = 3'h7;
    rx_line_idle = 1'b0;
    tx_shift_take = 1'b0;
    tx_shift_done = 1'b0;
  end
  // one finished character, qualifiers valid only with the strobe
  task automatic send_char(input logic [8:0] c, input logic [2:0] e);
    @(posedge core_clk);
    rx_char_ready <= 1'b1;
    rx_char_data <= c;
    rx_err <= e;
    @(posedge core_clk);
    rx_char_ready <= 1'b0;
    rx_char_data <= ~c;
    rx_err <= ~e;
    @(negedge core_clk);
  endtask
  // idle line seen by the receiver
  task automatic pulse_idle();
    @(posedge core_clk);
    rx_line_idle <= 1'b1;
    @(posedge core_clk);
    rx_line_idle <= 1'b0;
    @(negedge core_clk);
  endtask
  // falling edge on the pin, held long enough for any synchroniser
  task automatic fall_edge();
    @(posedge core_clk);
    rx_pin <= 1'b0;
    repeat (4) @(posedge core_clk);
    rx_pin <= 1'b1;
    repeat (4) @(negedge core_clk);
  endtask
  // shifter takes the buffer; unknown result if no load pulse comes
  task automatic take_char(output logic [8:0] t);
    t = 'x;
    @(posedge core_clk);
    tx_shift_take <= 1'b1;
    @(posedge core_clk);
    tx_shift_take <= 1'b0;
    repeat (4) begin
      @(negedge core_clk);
      if (tx_shift_load === 1'b1) t = tx_shift_data;
    end
    @(posedge core_clk);
    tx_shift_done <= 1'b1;
    @(posedge core_clk);
    tx_shift_done <= 1'b0;
    @(negedge core_clk);
  endtask
endmodule

/* testbench/usf_core_tb.sv */
// self-checking bench for the serial flag and nine-bit block
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); \
    end \
  end
module usf_core_tb;
  import usf_pkg::*;
  logic       core_clk;
  logic       sys_rst;
  logic       clk_en;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       rx_pin;
  logic       rx_rdy;
  logic [8:0] rx_data;
  logic [2:0] rx_err;
  logic       rx_idle;
  logic       tx_take;
  logic       tx_done;
  logic [8:0] tx_data;
  logic       tx_load;
  logic       nine_bit_mode;
  logic       rx_on;
  logic       irq;
  int         error_cnt;
  int         checks_done;

  usf_core u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_pin(rx_pin), .rx_char_ready(rx_rdy),
    .rx_char_data(rx_data), .rx_noise(rx_err[2]), .rx_framing(rx_err[1]),
    .rx_parity(rx_err[0]), .rx_line_idle(rx_idle), .tx_shift_take(tx_take),
    .tx_shift_done(tx_done), .tx_shift_data(tx_data), .tx_shift_load(tx_load),
    .nine_bit_mode(nine_bit_mode), .rx_on(rx_on), .irq(irq));
  usf_peer_model u_peer (.core_clk(core_clk), .rx_pin(rx_pin), .rx_char_ready(rx_rdy),
    .rx_char_data(rx_data), .rx_err(rx_err), .rx_line_idle(rx_idle),
    .tx_shift_take(tx_take), .tx_shift_done(tx_done), .tx_shift_data(tx_data),
    .tx_shift_load(tx_load));

  // 50 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // expected status one: transmit side idle, receive flags as given
  function automatic logic [7:0] st1(input logic f, input logic i, input logic o,
                                      input logic [2:0] e);
    return {2'b11, f, i, o, e};
  endfunction
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(negedge core_clk);
  endtask
  // read data is only valid in the cycle after the strobe
  task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    `CHK(reg_rdata, e)
  endtask
  task automatic print_verdict;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles of the tests
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    print_verdict();
  end
  // main sequence
  initial begin
    int         i;
    logic [7:0] d;
    logic [2:0] e;
    logic [8:0] t;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    error_cnt = 0;
    checks_done = 0;
    void'($urandom(32'hEEC5476F));
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    // reset state, read-only status, unmapped address
    chk_rd(ADDR_STATUS_ONE, st1(0, 0, 0, 3'h0));
    for (i = 2; i < 5; i++) chk_rd(4'(i), RST_CONTROL);
    wr(ADDR_STATUS_ONE, 8'h3F);
    chk_rd(ADDR_STATUS_ONE, st1(0, 0, 0, 3'h0));
    wr(4'h8, 8'hFF);
    chk_rd(4'h8, 8'h00);
    `CHK(irq, 1'b0)
    // random characters; a data read alone must not clear
    for (i = 0; i < 8; i++) begin
      d = 8'($urandom);
      e = (i == 0) ? 3'h7 : 3'($urandom);
      u_peer.send_char({1'b0, d}, e);
      chk_rd(ADDR_DATA, d);
      chk_rd(ADDR_STATUS_ONE, st1(1, 0, 0, e));
      chk_rd(ADDR_DATA, d);
      chk_rd(ADDR_STATUS_ONE, st1(0, 0, 0, 3'h0));
    end
    // overrun keeps the first character, drops the erroneous second
    u_peer.send_char(9'h0A5, 3'h0);
    u_peer.send_char(9'h05A, 3'h7);
    chk_rd(ADDR_STATUS_ONE, st1(1, 0, 1, 3'h0));
    chk_rd(ADDR_DATA, 8'hA5);
    chk_rd(ADDR_STATUS_ONE, st1(0, 0, 0, 3'h0));
    // idle flag clears and stays clear until a new character
    u_peer.send_char(9'h011, 3'h0);
    u_peer.pulse_idle();
    chk_rd(ADDR_STATUS_ONE, st1(1, 1, 0, 3'h0));
    chk_rd(ADDR_DATA, 8'h11);
    chk_rd(ADDR_STATUS_ONE, st1(0, 0, 0, 3'h0));
    u_peer.pulse_idle();
    chk_rd(ADDR_STATUS_ONE, st1(0, 0, 0, 3'h0));
    // interrupt raised, masked and cleared
    wr(ADDR_IRQ_STATUS, 8'h3F);
    wr(ADDR_IRQ_MASK, 8'h01);
    u_peer.send_char(9'h033, 3'h0);
    `CHK(irq, 1'b1)
    wr(ADDR_IRQ_MASK, 8'h00);
    `CHK(irq, 1'b0)
    wr(ADDR_IRQ_STATUS, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h01);
    `CHK(irq, 1'b0)
    u_peer.pulse_idle();
    chk_rd(ADDR_STATUS_ONE, st1(1, 1, 0, 3'h0));
    chk_rd(ADDR_DATA, 8'h33);
    // edge flag: ignored while receiver off, write one clears
    u_peer.fall_edge();
    chk_rd(ADDR_STATUS_TWO, 8'h00);
    wr(ADDR_CONTROL_TWO, 8'h84);
    `CHK(rx_on, 1'b1)
    `CHK(irq, 1'b1)
    u_peer.fall_edge();
    chk_rd(ADDR_STATUS_TWO, 8'h80);
    wr(ADDR_STATUS_TWO, 8'h00);
    chk_rd(ADDR_STATUS_TWO, 8'h80);
    wr(ADDR_STATUS_TWO, 8'h80);
    chk_rd(ADDR_STATUS_TWO, 8'h00);
    // nine-bit transmit; stored ninth bit reused by later characters
    wr(ADDR_CONTROL_ONE, 8'h10);
    `CHK(nine_bit_mode, 1'b1)
    wr(ADDR_CONTROL_THREE, 8'h40);
    chk_rd(ADDR_CONTROL_THREE, 8'h40);
    for (i = 0; i < 3; i++) begin
      d = 8'($urandom);
      wr(ADDR_DATA, d);
      u_peer.take_char(t);
      `CHK(t, {1'b1, d})
    end
    u_peer.send_char({1'b1, d}, 3'h0);
    chk_rd(ADDR_CONTROL_THREE, 8'hC0);
    u_peer.pulse_idle();
    chk_rd(ADDR_STATUS_ONE, st1(1, 1, 0, 3'h0));
    chk_rd(ADDR_DATA, d);
    // back to eight bits: ninth bit neither sent nor received
    wr(ADDR_CONTROL_ONE, 8'h00);
    wr(ADDR_DATA, 8'h3C);
    u_peer.take_char(t);
    `CHK(t, 9'h03C)
    u_peer.send_char(9'h1FF, 3'h0);
    chk_rd(ADDR_CONTROL_THREE, 8'h40);
    // frozen clock enable: the length bit write must not land
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(ADDR_CONTROL_ONE, 8'h10);
    @(posedge core_clk);
    clk_en <= 1'b1;
    chk_rd(ADDR_CONTROL_ONE, 8'h00);
    `CHK(nine_bit_mode, 1'b0)
    print_verdict();
  end
endmodule
